//--- logic/dpsr_ctr.sv
`timescale 1ns/10ps
`default_nettype none
module dpsr_ctr
    import dpsr_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          run,
    input  wire logic          load_n,
    input  wire logic          adv_n,
    input  wire logic          clr_n,
    input  wire logic [AW-1:0] load_addr,
    output logic      [AW-1:0] acc_addr
);
    logic [AW-1:0] cnt_q;
    logic [AW-1:0] cnt_inc;
    assign cnt_inc = cnt_q + AW'(CTR_STEP);
    // clear beats load, load beats advance
    assign acc_addr = !clr_n  ? AW'(CTR_ZERO) :
                      !load_n ? load_addr :
                      !adv_n  ? cnt_inc : cnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (run) begin
            cnt_q <= acc_addr;
        end
    end
endmodule // dpsr_ctr
`default_nettype wire

//--- logic/dpsr_dev.sv
`timescale 1ns/10ps
`default_nettype none
module dpsr_dev
    import dpsr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int LW = LANE_W
) (
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    dpsr_if.mem_end     port_a,
    dpsr_if.mem_end     port_b,
    output logic [NPORT-1:0] port_active
);
    localparam int DW = NLANE * LW;
    localparam int DP = 1 << AW;

    // ========================================
    // gather both ports into arrays
    logic [AW-1:0]    in_addr  [NPORT];
    logic [NPORT-1:0] in_ads_n;
    logic [NPORT-1:0] in_cs_lo;
    logic [NPORT-1:0] in_cs_hi;
    logic [NPORT-1:0] in_adv_n;
    logic [NPORT-1:0] in_clr_n;
    logic [NLANE-1:0] in_bs_n  [NPORT];
    logic [NPORT-1:0] in_oe_n;
    logic [NPORT-1:0] in_wr_n;
    logic [NPORT-1:0] in_lat;
    logic [NPORT-1:0] in_run;
    logic [DW-1:0]    in_dq    [NPORT];
    logic [DW-1:0]    out_dq   [NPORT];
    logic [NLANE-1:0] out_oe   [NPORT];

    assign in_addr[0]  = port_a.addr;
    assign in_ads_n[0] = port_a.address_load_strobe_n;
    assign in_cs_lo[0] = port_a.chip_select_active_low;
    assign in_cs_hi[0] = port_a.chip_select_active_high;
    assign in_adv_n[0] = port_a.burst_advance_n;
    assign in_clr_n[0] = port_a.burst_clear_n;
    assign in_bs_n[0]  = {port_a.high_byte_select_n,
                          port_a.low_byte_select_n};
    assign in_oe_n[0]  = port_a.out_enable_n;
    assign in_wr_n[0]  = port_a.rd_wr_n;
    assign in_lat[0]   = port_a.latency_mode_select;
    assign in_run[0]   = port_a.clk_run;
    assign in_dq[0]    = port_a.dq;
    assign port_a.mem_dq    = out_dq[0];
    assign port_a.mem_dq_oe = out_oe[0];

    assign in_addr[1]  = port_b.addr;
    assign in_ads_n[1] = port_b.address_load_strobe_n;
    assign in_cs_lo[1] = port_b.chip_select_active_low;
    assign in_cs_hi[1] = port_b.chip_select_active_high;
    assign in_adv_n[1] = port_b.burst_advance_n;
    assign in_clr_n[1] = port_b.burst_clear_n;
    assign in_bs_n[1]  = {port_b.high_byte_select_n,
                          port_b.low_byte_select_n};
    assign in_oe_n[1]  = port_b.out_enable_n;
    assign in_wr_n[1]  = port_b.rd_wr_n;
    assign in_lat[1]   = port_b.latency_mode_select;
    assign in_run[1]   = port_b.clk_run;
    assign in_dq[1]    = port_b.dq;
    assign port_b.mem_dq    = out_dq[1];
    assign port_b.mem_dq_oe = out_oe[1];

    // ========================================
    // shared array, one bank per byte lane
    logic [LW-1:0]    mem [NLANE][DP];
    logic [AW-1:0]    acc_addr [NPORT];
    logic [NLANE-1:0] wr_lane  [NPORT];
    logic [DW-1:0]    wdata_q  [NPORT];
    logic [DW-1:0]    rd_now   [NPORT];

    // port b lands last on a same-word clash; callers must not rely on it
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < NPORT; p++) begin
            for (int l = 0; l < NLANE; l++) begin
                if (wr_lane[p][l]) begin
                    mem[l][acc_addr[p]] <= wdata_q[p][l*LW +: LW];
                end
            end
        end
    end

    // ========================================
    // per-port logic
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic [AW-1:0]    addr_q;
        logic             ads_n_q;
        logic             cs_lo_q;
        logic             cs_hi_q;
        logic             adv_n_q;
        logic             clr_n_q;
        logic [NLANE-1:0] bs_n_q;
        logic             oe_n_q;
        logic             wr_n_q;
        logic             lat_q;
        logic             sel;
        logic             rd_req;
        logic [NLANE-1:0] lane_en;
        logic [DW-1:0]    stage_q;
        logic [NLANE-1:0] stage_en_q;
        logic [DW-1:0]    out_q;
        logic [NLANE-1:0] oe_q;
        logic             act_q;

        // input registers, idle with chip deselected
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                addr_q     <= '0;
                ads_n_q    <= 1'b1;
                cs_lo_q    <= 1'b1;
                cs_hi_q    <= 1'b0;
                adv_n_q    <= 1'b1;
                clr_n_q    <= 1'b1;
                bs_n_q     <= '1;
                oe_n_q     <= 1'b1;
                wr_n_q     <= 1'b1;
                lat_q      <= LAT_FLOW;
                wdata_q[p] <= '0;
            end else if (in_run[p]) begin
                addr_q     <= in_addr[p];
                ads_n_q    <= in_ads_n[p];
                cs_lo_q    <= in_cs_lo[p];
                cs_hi_q    <= in_cs_hi[p];
                adv_n_q    <= in_adv_n[p];
                clr_n_q    <= in_clr_n[p];
                bs_n_q     <= in_bs_n[p];
                oe_n_q     <= in_oe_n[p];
                wr_n_q     <= in_wr_n[p];
                lat_q      <= in_lat[p];
                wdata_q[p] <= in_dq[p];
            end
        end

        dpsr_ctr #(.AW(AW)) u_ctr (
            .ref_clk   (ref_clk),
            .rst_n     (rst_n),
            .run       (in_run[p]),
            .load_n    (ads_n_q),
            .adv_n     (adv_n_q),
            .clr_n     (clr_n_q),
            .load_addr (addr_q),
            .acc_addr  (acc_addr[p])
        );

        assign sel    = !cs_lo_q && cs_hi_q && in_run[p];
        assign rd_req = sel && wr_n_q;
        assign wr_lane[p] = (sel && !wr_n_q) ? ~bs_n_q : '0;
        assign lane_en = (rd_req && !oe_n_q) ? ~bs_n_q : '0;

        for (genvar l = 0; l < NLANE; l++) begin : g_rd
            assign rd_now[p][l*LW +: LW] = mem[l][acc_addr[p]];
        end

        // flow takes the array word, pipelined the staged one
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                stage_q    <= '0;
                stage_en_q <= '0;
                out_q      <= '0;
                oe_q       <= '0;
                act_q      <= 1'b0;
            end else if (in_run[p]) begin
                stage_q    <= rd_now[p];
                stage_en_q <= lane_en;
                act_q      <= sel;
                if (lat_q == LAT_PIPE) begin
                    out_q <= stage_q;
                    oe_q  <= stage_en_q;
                end else begin
                    out_q <= rd_now[p];
                    oe_q  <= lane_en;
                end
            end
        end

        assign out_dq[p]      = out_q;
        assign out_oe[p]      = oe_q;
        assign port_active[p] = act_q;
    end
endmodule // dpsr_dev
`default_nettype wire

//--- logic/dpsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module dpsr_host
    import dpsr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int LW = LANE_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    dpsr_if.ctl_end                link
);
    localparam int DW = NLANE * LW;

    // ========================================
    // bus decode
    logic          setup;
    logic          wr_ok;
    logic          hit_ctrl;
    logic          hit_cmd;
    logic          hit_wd;
    logic          hit_rd;
    logic          hit_st;
    logic          hit_any;
    logic [1:0]    ctrl_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] rdata_q;
    logic          valid_q;
    logic [31:0]   rd_mux;
    dpsr_op_t      op;

    assign setup    = psel && !penable;
    assign wr_ok    = psel && penable && pready && pwrite;
    assign hit_ctrl = (paddr == OFF_CTRL);
    assign hit_cmd  = (paddr == OFF_CMD);
    assign hit_wd   = (paddr == OFF_WDATA);
    assign hit_rd   = (paddr == OFF_RDATA);
    assign hit_st   = (paddr == OFF_STAT);
    assign hit_any  = hit_ctrl || hit_cmd || hit_wd || hit_rd || hit_st;
    assign rd_mux   = hit_ctrl ? 32'(ctrl_q) :
                      hit_wd   ? 32'(wdata_q) :
                      hit_rd   ? 32'(rdata_q) :
                      hit_st   ? 32'(valid_q) : 32'h0000_0000;
    assign op = dpsr_op_t'(pwdata[CMD_OP_LSB +: 2]);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_any;
            prdata  <= setup ? rd_mux : '0;
        end
    end

    // ========================================
    // registers and capture
    logic [NLANE-1:0] lane_seen;
    assign lane_seen = link.mem_dq_oe;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= CTRL_RESET;
            wdata_q <= '0;
            rdata_q <= '0;
            valid_q <= 1'b0;
        end else begin
            if (wr_ok && hit_ctrl) ctrl_q  <= pwdata[1:0];
            if (wr_ok && hit_wd)   wdata_q <= pwdata[DW-1:0];
            for (int l = 0; l < NLANE; l++) begin
                if (lane_seen[l]) rdata_q[l*LW +: LW] <= link.dq[l*LW +: LW];
            end
            // a capture in the clearing cycle keeps the flag set
            if (|lane_seen) valid_q <= 1'b1;
            else if (wr_ok && hit_st && pwdata[STAT_VALID_BIT]) valid_q <= 1'b0;
        end
    end

    // ========================================
    // pin drive: one cycle per command
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.addr                    <= '0;
            link.address_load_strobe_n   <= 1'b1;
            link.chip_select_active_low  <= 1'b1;
            link.chip_select_active_high <= 1'b0;
            link.burst_advance_n         <= 1'b1;
            link.burst_clear_n           <= 1'b1;
            link.low_byte_select_n       <= 1'b1;
            link.high_byte_select_n      <= 1'b1;
            link.out_enable_n            <= 1'b1;
            link.rd_wr_n                 <= 1'b1;
            link.host_dq                 <= '0;
            link.host_dq_oe              <= '0;
        end else if (wr_ok && hit_cmd) begin
            link.addr <= pwdata[CMD_ADDR_LSB +: AW];
            link.address_load_strobe_n   <= (op != DPSR_OP_LOAD);
            link.chip_select_active_low  <= 1'b0;
            link.chip_select_active_high <= 1'b1;
            link.burst_advance_n         <= (op != DPSR_OP_ADV);
            link.burst_clear_n           <= (op != DPSR_OP_CLEAR);
            link.low_byte_select_n       <= !pwdata[CMD_LO_BIT];
            link.high_byte_select_n      <= !pwdata[CMD_HI_BIT];
            link.out_enable_n            <= !pwdata[CMD_OE_BIT];
            link.rd_wr_n                 <= !pwdata[CMD_WR_BIT];
            link.host_dq                 <= wdata_q;
            link.host_dq_oe <= pwdata[CMD_WR_BIT] ?
                {pwdata[CMD_HI_BIT], pwdata[CMD_LO_BIT]} : '0;
        end else begin
            link.address_load_strobe_n   <= 1'b1;
            link.chip_select_active_low  <= 1'b1;
            link.chip_select_active_high <= 1'b0;
            link.burst_advance_n         <= 1'b1;
            link.burst_clear_n           <= 1'b1;
            link.out_enable_n            <= 1'b1;
            link.rd_wr_n                 <= 1'b1;
            link.host_dq_oe              <= '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.latency_mode_select <= LAT_FLOW;
            link.clk_run             <= 1'b1;
        end else begin
            link.latency_mode_select <= ctrl_q[CTRL_LAT_BIT];
            link.clk_run             <= ctrl_q[CTRL_RUN_BIT];
        end
    end
endmodule // dpsr_host
`default_nettype wire

//--- logic/dpsr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dpsr_if
    import dpsr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int LW = LANE_W
);
    logic [AW-1:0]      addr;
    logic               address_load_strobe_n;
    logic               chip_select_active_low;
    logic               chip_select_active_high;
    logic               burst_advance_n;
    logic               burst_clear_n;
    logic               low_byte_select_n;
    logic               high_byte_select_n;
    logic               out_enable_n;
    logic               rd_wr_n;
    logic               latency_mode_select;
    logic               clk_run;
    logic [NLANE*LW-1:0] host_dq;
    logic [NLANE-1:0]    host_dq_oe;
    logic [NLANE*LW-1:0] mem_dq;
    logic [NLANE-1:0]    mem_dq_oe;
    logic [NLANE*LW-1:0] dq;
    // resolved shared data wire, lane by lane
    for (genvar l = 0; l < NLANE; l++) begin : g_res
        assign dq[l*LW +: LW] = mem_dq_oe[l] ? mem_dq[l*LW +: LW] :
                                host_dq_oe[l] ? host_dq[l*LW +: LW] : '0;
    end
    modport mem_end (
        input  addr, address_load_strobe_n, chip_select_active_low,
        input  chip_select_active_high, burst_advance_n, burst_clear_n,
        input  low_byte_select_n, high_byte_select_n, out_enable_n,
        input  rd_wr_n, latency_mode_select, clk_run, dq,
        output mem_dq, mem_dq_oe
    );
    modport ctl_end (
        output addr, address_load_strobe_n, chip_select_active_low,
        output chip_select_active_high, burst_advance_n, burst_clear_n,
        output low_byte_select_n, high_byte_select_n, out_enable_n,
        output rd_wr_n, latency_mode_select, clk_run, host_dq, host_dq_oe,
        input  dq, mem_dq_oe
    );
endinterface
`default_nettype wire

//--- logic/dpsr_pkg.sv
`default_nettype none
package dpsr_pkg;
    // ========================================
    // array shape
    localparam int ADDR_W = 16;
    localparam int LANE_W = 9;
    localparam int NLANE  = 2;
    localparam int NPORT  = 2;
    localparam int DATA_W = LANE_W * NLANE;
    localparam int DEPTH  = 1 << ADDR_W;
    localparam logic [ADDR_W-1:0] CTR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] CTR_STEP = 16'h0001;
    localparam logic LAT_FLOW = 1'b0;
    localparam logic LAT_PIPE = 1'b1;
    // ========================================
    // controller register map
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CMD   = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0C;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam int CTRL_LAT_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_OP_LSB   = 16;
    localparam int CMD_WR_BIT   = 18;
    localparam int CMD_LO_BIT   = 19;
    localparam int CMD_HI_BIT   = 20;
    localparam int CMD_OE_BIT   = 21;
    localparam int STAT_VALID_BIT = 0;
    typedef enum logic [1:0] {
        DPSR_OP_LOAD, DPSR_OP_ADV, DPSR_OP_CLEAR, DPSR_OP_HOLD
    } dpsr_op_t;
endpackage
`default_nettype wire

//--- test/dpsr_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dpsr_assertions
    import dpsr_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic             address_load_strobe_n,
    input wire logic             chip_select_active_low,
    input wire logic             chip_select_active_high,
    input wire logic             burst_advance_n,
    input wire logic             burst_clear_n,
    input wire logic             low_byte_select_n,
    input wire logic             high_byte_select_n,
    input wire logic             out_enable_n,
    input wire logic             rd_wr_n,
    input wire logic             latency_mode_select,
    input wire logic             clk_run,
    input wire logic [NLANE-1:0] host_dq_oe,
    input wire logic [NLANE-1:0] mem_dq_oe
);
    // ========================================
    // decode
    wire sel = !chip_select_active_low && chip_select_active_high;
    wire [1:0] rd_lanes = {2{sel && rd_wr_n && !out_enable_n}}
                          & ~{high_byte_select_n, low_byte_select_n};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // sequences
    sequence s_flow_go;
        !latency_mode_select && clk_run ##1 clk_run;
    endsequence
    sequence s_pipe_go;
        latency_mode_select && clk_run ##1 clk_run [*2];
    endsequence
    // ========================================
    // properties
    a_flow_lane_drive: assert property (s_flow_go |-> ##1
        mem_dq_oe == $past(rd_lanes, 2)) else $error("flow drive wrong");
    a_pipe_lane_drive: assert property (s_pipe_go |-> ##1
        mem_dq_oe == $past(rd_lanes, 3)) else $error("pipe drive wrong");
    a_pipe_not_early: assert property ((latency_mode_select
        && clk_run && rd_lanes != 0) ##1 clk_run |-> ##1 mem_dq_oe == 0)
        else $error("pipelined data too early");
    a_stopped_hold: assert property (!clk_run
        |=> $stable(mem_dq_oe))
        else $error("drive changed with clock stopped");
    a_read_one_pulse: assert property ((mem_dq_oe != 0) && clk_run
        |=> mem_dq_oe == 0) else $error("drive longer than one cycle");
    a_cmd_one_cycle: assert property (sel |=> !sel)
        else $error("command held past one cycle");
    a_host_drive_write: assert property (host_dq_oe != 0
        |-> sel && !rd_wr_n) else $error("host drives outside write");
    a_idle_quiet: assert property (!sel |-> address_load_strobe_n
        && burst_advance_n && burst_clear_n && out_enable_n && rd_wr_n
        && host_dq_oe == 0) else $error("idle link not quiet");
endmodule // dpsr_assertions
`default_nettype wire

//--- test/sync_dual_port_ram_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module sync_dual_port_ram_port_tb
    import dpsr_pkg::*;
;
    logic             ref_clk = 1'b0;
    logic             rst_n   = 1'b0;
    logic [1:0]       psel    = '0;
    logic [1:0]       penable = '0;
    logic [1:0]       pwrite  = '0;
    logic [7:0]       paddr [2] = '{8'h00, 8'h00};
    logic [31:0]      pwdata [2] = '{32'h0, 32'h0};
    wire  [1:0]       pready;
    wire  [1:0]       pslverr;
    wire  [31:0]      prdata [2];
    wire  [NPORT-1:0] port_active;
    int               mismatches = 0;
    int               checks = 0;
    localparam logic [1:0] LD = DPSR_OP_LOAD;
    localparam logic [1:0] AD = DPSR_OP_ADV;
    localparam logic [1:0] CL = DPSR_OP_CLEAR;
    localparam logic [1:0] HD = DPSR_OP_HOLD;
    always #25 ref_clk = ~ref_clk;
    // ========================================
    // structure
    dpsr_if lnk_a ();
    dpsr_if lnk_b ();
    dpsr_dev i_dpsr_dev (.ref_clk(ref_clk), .rst_n(rst_n), .port_a(lnk_a),
        .port_b(lnk_b), .port_active(port_active));
    for (genvar g = 0; g < 2; g++) begin : g_host
        if (g == 0) begin : g_sel
            dpsr_host i_dpsr_host (.ref_clk(ref_clk), .rst_n(rst_n),
                .psel(psel[g]), .penable(penable[g]), .pwrite(pwrite[g]),
                .paddr(paddr[g]), .pwdata(pwdata[g]), .prdata(prdata[g]),
                .pready(pready[g]), .pslverr(pslverr[g]), .link(lnk_a));
        end else begin : g_sel
            dpsr_host i_dpsr_host (.ref_clk(ref_clk), .rst_n(rst_n),
                .psel(psel[g]), .penable(penable[g]), .pwrite(pwrite[g]),
                .paddr(paddr[g]), .pwdata(pwdata[g]), .prdata(prdata[g]),
                .pready(pready[g]), .pslverr(pslverr[g]), .link(lnk_b));
        end
    end
    dpsr_assertions i_dpsr_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
        .address_load_strobe_n(lnk_a.address_load_strobe_n),
        .chip_select_active_low(lnk_a.chip_select_active_low),
        .chip_select_active_high(lnk_a.chip_select_active_high),
        .burst_advance_n(lnk_a.burst_advance_n),
        .burst_clear_n(lnk_a.burst_clear_n),
        .low_byte_select_n(lnk_a.low_byte_select_n),
        .high_byte_select_n(lnk_a.high_byte_select_n),
        .out_enable_n(lnk_a.out_enable_n), .rd_wr_n(lnk_a.rd_wr_n),
        .latency_mode_select(lnk_a.latency_mode_select),
        .clk_run(lnk_a.clk_run), .host_dq_oe(lnk_a.host_dq_oe),
        .mem_dq_oe(lnk_a.mem_dq_oe));
    // ========================================
    // tasks
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input int p, input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        @(posedge ref_clk);
        psel[p] <= 1'b1;
        pwrite[p] <= w;
        paddr[p] <= a;
        pwdata[p] <= wd;
        @(posedge ref_clk);
        penable[p] <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready[p] !== 1'b1 && n < 20);
        rd = prdata[p];
        er = pslverr[p];
        psel[p] <= 1'b0;
        penable[p] <= 1'b0;
        if (pready[p] !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic acc(input int p, input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] ex, input logic eer);
        logic [31:0] r;
        logic        e;
        apb(p, w, a, d, r, e);
        `CHK(e, eer)
        if (!w) `CHK(r, ex)
    endtask
    function automatic logic [31:0] cmd(logic [15:0] a, logic [1:0] op,
        logic w, logic [1:0] ln, logic oe);
        return {10'h000, oe, ln, w, op, a};
    endfunction
    task automatic mem_wr(input int p, input logic [15:0] a,
        input logic [1:0] op, input logic [1:0] ln, input logic [17:0] d);
        acc(p, 1'b1, OFF_WDATA, {14'h0000, d}, 32'h0, 1'b0);
        acc(p, 1'b1, OFF_CMD, cmd(a, op, 1'b1, ln, 1'b0), 32'h0, 1'b0);
    endtask
    task automatic mem_rd(input int p, input logic [15:0] a,
        input logic [1:0] op, input logic [1:0] ln, input logic oe,
        input logic [17:0] ex);
        logic [31:0] r;
        logic        e;
        logic        v;
        logic [17:0] m;
        m = {{9{ln[1]}}, {9{ln[0]}}};
        acc(p, 1'b1, OFF_CMD, cmd(a, op, 1'b0, ln, oe), 32'h0, 1'b0);
        v = 1'b0;
        for (int i = 0; i < 6 && v !== 1'b1; i++) begin
            apb(p, 1'b0, OFF_STAT, 32'h0, r, e);
            v = r[STAT_VALID_BIT];
        end
        `CHK(v, oe && (ln != 2'b00))
        if (v === 1'b1) begin
            apb(p, 1'b0, OFF_RDATA, 32'h0, r, e);
            `CHK(r[17:0] & m, ex & m)
            acc(p, 1'b1, OFF_STAT, 32'h1, 32'h0, 1'b0);
        end
    endtask
    // ========================================
    // sequence of tests
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        `CHK(port_active, 2'b00)
        for (int p = 0; p < 2; p++) begin
            acc(p, 1'b0, OFF_CTRL, 32'h0, 32'(CTRL_RESET), 1'b0);
            acc(p, 1'b0, OFF_CMD, 32'h0, 32'h0, 1'b0);
            acc(p, 1'b0, OFF_STAT, 32'h0, 32'h0, 1'b0);
            acc(p, 1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        end
        mem_wr(0, 16'h0010, LD, 2'b11, 18'h2A5A5);
        mem_rd(1, 16'h0010, LD, 2'b11, 1'b1, 18'h2A5A5);
        mem_wr(0, 16'h0010, LD, 2'b01, 18'h00000);
        mem_rd(1, 16'h0010, LD, 2'b11, 1'b1, 18'h2A400);
        mem_wr(0, 16'h0010, LD, 2'b10, 18'h3FFFF);
        mem_rd(0, 16'h0010, LD, 2'b11, 1'b1, 18'h3FE00);
        mem_rd(0, 16'h0010, LD, 2'b01, 1'b1, 18'h3FE00);
        mem_rd(0, 16'h0010, LD, 2'b11, 1'b0, 18'h00000);
        mem_rd(0, 16'h0010, LD, 2'b00, 1'b1, 18'h00000);
        mem_wr(0, 16'h1234, CL, 2'b11, 18'h00111);
        mem_rd(1, 16'h0000, LD, 2'b11, 1'b1, 18'h00111);
        mem_wr(0, 16'hFFFF, LD, 2'b11, 18'h00222);
        mem_wr(0, 16'h0000, AD, 2'b11, 18'h00333);
        mem_rd(1, 16'h0000, LD, 2'b11, 1'b1, 18'h00333);
        mem_rd(0, 16'h5555, HD, 2'b11, 1'b1, 18'h00333);
        acc(0, 1'b1, OFF_CTRL, 32'h3, 32'h0, 1'b0);
        acc(0, 1'b0, OFF_CTRL, 32'h0, 32'h3, 1'b0);
        mem_rd(0, 16'hFFFF, LD, 2'b11, 1'b1, 18'h00222);
        mem_rd(0, 16'h0000, AD, 2'b11, 1'b1, 18'h00333);
        acc(0, 1'b1, OFF_CTRL, 32'h2, 32'h0, 1'b0);
        mem_wr(0, 16'h0020, LD, 2'b11, 18'h0ABCD);
        acc(0, 1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
        mem_wr(0, 16'h0020, LD, 2'b11, 18'h11111);
        acc(0, 1'b1, OFF_CTRL, 32'h2, 32'h0, 1'b0);
        mem_rd(0, 16'h0020, LD, 2'b11, 1'b1, 18'h0ABCD);
        acc(1, 1'b1, OFF_CTRL, 32'h3, 32'h0, 1'b0);
        mem_rd(1, 16'h0020, LD, 2'b11, 1'b1, 18'h0ABCD);
        mem_rd(1, 16'h0010, LD, 2'b10, 1'b1, 18'h3FE00);
        acc(1, 1'b1, OFF_CTRL, 32'h2, 32'h0, 1'b0);
        repeat (4) @(posedge ref_clk);
        `CHK(port_active, 2'b00)
        summarize();
    end
endmodule // sync_dual_port_ram_port_tb
`default_nettype wire
